// ==== lsm_monitor.sv ====
`timescale 1ns/10ps
// Overview of operation
// - bit7 high when no high-speed input
// - bit6 high when no low-frequency signaling
// - bit5 high for high-speed input type
// - bits4..0 report lane operating mode
// - status bit7 reports far termination sensed
// - status bit6 reports common-mode state
// - status bit5 high in compliance mode outside safe configuration codes
// - compliance state cycles between fixed bounds
// - adjacent-lane ping advances compliance state
// - swing setting low five bits, rest zero
// - lock byte bit5 reports recovery lock
// - lock byte bit4 reports synth lock
// - equalizer byte bit5 reports calibration done
// - equalizer byte bits3..0 hold adapted code
// - bit6 mirrors power-down, one after reset
// - bit4 holds decoded dual-lane flag
// - bit3 holds decoded data-rate flag
// - bit2 holds decoded warm-restart flag
// - safe configuration codes force safe lane state
module lsm_monitor
   import lsm_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   // management serial port
   input  wire logic       scl,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // lane configuration
   input  wire logic [3:0] lane_config_select,
   // receive path b status
   input  wire logic       rxb_highspeed_quiet_flag,
   input  wire logic       rxb_lowfreq_signal_quiet_flag,
   input  wire logic       rxb_input_type_flag,
   input  wire logic [4:0] rxb_lane_operating_mode,
   input  wire logic       rxb_far_termination_seen,
   input  wire logic       rxb_common_mode_state,
   input  wire logic       rxb_compliance_active,
   input  wire logic       rxb_adjacent_ping,
   input  wire logic [4:0] rxb_swing_emphasis_setting,
   // transmit path a status
   input  wire logic       txa_highspeed_quiet_flag,
   input  wire logic       txa_lowfreq_signal_quiet_flag,
   input  wire logic       txa_input_type_flag,
   input  wire logic [4:0] txa_lane_operating_mode,
   input  wire logic       txa_far_termination_seen,
   input  wire logic       txa_common_mode_state,
   input  wire logic       txa_compliance_active,
   input  wire logic       txa_adjacent_ping,
   input  wire logic       txa_recovery_loop_locked,
   input  wire logic       txa_synth_loop_locked,
   input  wire logic       txa_equalizer_cal_finished,
   input  wire logic [3:0] txa_equalizer_code,
   input  wire logic       txa_powerdown_n_status,
   input  wire logic       txa_msg_dual_lane_flag,
   input  wire logic       txa_msg_data_rate_flag,
   input  wire logic       txa_msg_warm_restart_flag
);

   typedef struct packed {
      lsm_i2c_st_t st;
      logic [3:0]  cnt;
      logic [7:0]  shift;
      logic [7:0]  tx;
      logic [7:0]  ptr;
      logic        rw;
      logic        nack;
      logic        sda_oe;
      logic        sda_out;
      logic        scl_d;
      logic        sda_d;
      logic [1:0]  age;
   } lsm_mon_t;

   lsm_mon_t   r;
   lsm_mon_t   next_r;
   logic       scl_s;
   logic       sda_s;
   logic       pd_n_s;
   logic [3:0] cfg_s;
   logic       b_hsq, b_lfq, b_type, b_term, b_cm, b_comp, b_ping;
   logic [4:0] b_mode, b_sw;
   logic       a_hsq, a_lfq, a_type, a_term, a_cm, a_comp, a_ping;
   logic       a_cdr, a_pll, a_eqd, a_dual, a_rate, a_warm;
   logic [4:0] a_mode;
   logic [3:0] a_eq;
   logic       safe;
   logic [4:0] b_comp_state, a_comp_state;
   logic [7:0] mode_b, sig_b, txset_b, lock_a, eq_a, pd_a, mode_a, sig_a;
   logic [7:0] rd_cur;
   logic [7:0] rd_nxt;
   logic       scl_rise, scl_fall, start_ev, stop_ev;

   lsm_sync #(.WIDTH(2), .RST_VAL(RST_BUS)) u_sync_bus (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .din     ({scl, sda_in}),
      .dout    ({scl_s, sda_s})
   );

   // power-down flag must read one straight out of reset
   lsm_sync #(.WIDTH(1), .RST_VAL(RST_PD_N)) u_sync_pd (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .din     (txa_powerdown_n_status),
      .dout    (pd_n_s)
   );

   // multi-bit codes may tear for one cycle while they change
   lsm_sync #(.WIDTH(43), .RST_VAL(RST_STATUS)) u_sync_status (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .din     ({lane_config_select, rxb_highspeed_quiet_flag,
                 rxb_lowfreq_signal_quiet_flag, rxb_input_type_flag,
                 rxb_lane_operating_mode, rxb_far_termination_seen,
                 rxb_common_mode_state, rxb_compliance_active, rxb_adjacent_ping,
                 rxb_swing_emphasis_setting, txa_highspeed_quiet_flag,
                 txa_lowfreq_signal_quiet_flag, txa_input_type_flag,
                 txa_lane_operating_mode, txa_far_termination_seen,
                 txa_common_mode_state, txa_compliance_active, txa_adjacent_ping,
                 txa_recovery_loop_locked, txa_synth_loop_locked,
                 txa_equalizer_cal_finished, txa_equalizer_code,
                 txa_msg_dual_lane_flag, txa_msg_data_rate_flag,
                 txa_msg_warm_restart_flag}),
      .dout    ({cfg_s, b_hsq, b_lfq, b_type, b_mode, b_term, b_cm, b_comp,
                 b_ping, b_sw, a_hsq, a_lfq, a_type, a_mode, a_term, a_cm,
                 a_comp, a_ping, a_cdr, a_pll, a_eqd, a_eq, a_dual, a_rate,
                 a_warm})
   );

   assign safe = (cfg_s <= CFG_SAFE_MAX);

   lsm_comp_step u_comp_b (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .comp_en    (b_comp && !safe),
      .ping       (b_ping),
      .comp_state (b_comp_state)
   );

   lsm_comp_step u_comp_a (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .comp_en    (a_comp && !safe),
      .ping       (a_ping),
      .comp_state (a_comp_state)
   );

   always_comb
   begin
      mode_b = 8'h00;
      mode_b[BIT_HS_QUIET] = b_hsq;
      mode_b[BIT_LF_QUIET] = b_lfq;
      mode_b[BIT_IN_TYPE] = b_type;
      mode_b[4:0] = safe ? LANE_MODE_SAFE : b_mode;
      mode_a = 8'h00;
      mode_a[BIT_HS_QUIET] = a_hsq;
      mode_a[BIT_LF_QUIET] = a_lfq;
      mode_a[BIT_IN_TYPE] = a_type;
      mode_a[4:0] = safe ? LANE_MODE_SAFE : a_mode;
      sig_b = 8'h00;
      sig_b[BIT_TERM] = b_term;
      sig_b[BIT_CM] = b_cm;
      sig_b[BIT_COMP_EN] = b_comp && !safe;
      sig_b[4:0] = b_comp_state;
      sig_a = 8'h00;
      sig_a[BIT_TERM] = a_term;
      sig_a[BIT_CM] = a_cm;
      sig_a[BIT_COMP_EN] = a_comp && !safe;
      sig_a[4:0] = a_comp_state;
      txset_b = {3'h0, b_sw};
      lock_a = 8'h00;
      lock_a[BIT_CDR] = a_cdr;
      lock_a[BIT_PLL] = a_pll;
      eq_a = 8'h00;
      eq_a[BIT_EQ_DONE] = a_eqd;
      eq_a[3:0] = a_eq;
      pd_a = 8'h00;
      pd_a[BIT_PD_N] = pd_n_s;
      pd_a[BIT_DUAL] = a_dual;
      pd_a[BIT_RATE] = a_rate;
      pd_a[BIT_WARM] = a_warm;
   end

   function automatic logic [7:0] reg_read(input logic [7:0] a);
      logic [7:0] v;
      v = RSVD_VALUE;
      case (a)
         OFF_RXB_MODE:  v = mode_b;
         OFF_RXB_SIG:   v = sig_b;
         OFF_RXB_TXSET: v = txset_b;
         OFF_TXA_LOCK:  v = lock_a;
         OFF_TXA_EQ:    v = eq_a;
         OFF_TXA_RSVD:  v = RSVD_VALUE;
         OFF_TXA_PD:    v = pd_a;
         OFF_TXA_MODE:  v = mode_a;
         OFF_TXA_SIG:   v = sig_a;
         default:       v = RSVD_VALUE;
      endcase
      return v;
   endfunction

   // a bare assign would miss status changes inside the function
   always_comb
   begin
      rd_cur = reg_read(r.ptr);
      rd_nxt = reg_read(r.ptr + 8'h01);
   end

   assign scl_rise = scl_s && !r.scl_d;
   assign scl_fall = !scl_s && r.scl_d;
   assign start_ev = scl_s && r.scl_d && r.sda_d && !sda_s;
   assign stop_ev  = scl_s && r.scl_d && !r.sda_d && sda_s;

   always_comb
   begin
      next_r = r;
      next_r.scl_d = scl_s;
      next_r.sda_d = sda_s;
      next_r.sda_out = 1'h0;
      if (r.age != 2'h3)
      begin
         next_r.age = r.age + 2'h1;
      end
      if (start_ev)
      begin
         next_r.st = ST_ADDR;
         next_r.cnt = 4'h0;
         next_r.sda_oe = 1'h0;
      end
      else if (stop_ev)
      begin
         next_r.st = ST_IDLE;
         next_r.sda_oe = 1'h0;
      end
      else
      begin
         case (r.st)
            ST_ADDR, ST_PTR, ST_WR_DATA:
            begin
               if (scl_rise)
               begin
                  next_r.shift = {r.shift[6:0], sda_s};
                  next_r.cnt = r.cnt + 4'h1;
               end
               else if (scl_fall && r.cnt == BITS_PER_BYTE)
               begin
                  next_r.cnt = 4'h0;
                  next_r.sda_oe = 1'h1;
                  next_r.st = ST_ACK_WR;
                  if (r.st == ST_ADDR)
                  begin
                     next_r.rw = r.shift[0];
                     next_r.sda_oe = (r.shift[7:1] == SLAVE_ADDR);
                     next_r.st = (r.shift[7:1] == SLAVE_ADDR) ? ST_ADDR_ACK : ST_IDLE;
                  end
                  else if (r.st == ST_PTR)
                  begin
                     next_r.ptr = r.shift;
                  end
               end
            end
            ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  next_r.tx = rd_cur;
                  next_r.sda_oe = r.rw && !rd_cur[7];
                  next_r.st = r.rw ? ST_RD_DATA : ST_PTR;
               end
            end
            ST_ACK_WR:
            begin
               if (scl_fall)
               begin
                  next_r.sda_oe = 1'h0;
                  next_r.st = ST_WR_DATA;
               end
            end
            ST_RD_DATA:
            begin
               if (scl_fall)
               begin
                  next_r.cnt = r.cnt + 4'h1;
                  next_r.tx = {r.tx[6:0], 1'h0};
                  next_r.sda_oe = !r.tx[6];
                  if (r.cnt == BITS_PER_BYTE - 4'h1)
                  begin
                     next_r.cnt = 4'h0;
                     next_r.sda_oe = 1'h0;
                     next_r.st = ST_RD_ACK;
                  end
               end
            end
            ST_RD_ACK:
            begin
               if (scl_rise)
               begin
                  next_r.nack = sda_s;
               end
               else if (scl_fall)
               begin
                  next_r.ptr = r.ptr + 8'h01;
                  next_r.tx = rd_nxt;
                  next_r.sda_oe = !r.nack && !rd_nxt[7];
                  next_r.st = r.nack ? ST_IDLE : ST_RD_DATA;
               end
            end
            default:
            begin
               next_r.sda_oe = 1'h0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         r <= '{st: ST_IDLE, scl_d: RST_BUS, sda_d: RST_BUS, default: '0};
      end
      else
      begin
         r <= next_r;
      end
   end

   assign sda_out = r.sda_out;
   assign sda_oe  = r.sda_oe;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   AST_HS_QUIET: assert property ((r.age == 2'h3) |->
      (mode_b[BIT_HS_QUIET] == $past(rxb_highspeed_quiet_flag, 2)))
      else $error("high-speed quiet bit wrong");
   AST_LF_QUIET: assert property ((r.age == 2'h3) |->
      (mode_a[BIT_LF_QUIET] == $past(txa_lowfreq_signal_quiet_flag, 2)))
      else $error("low-frequency quiet bit wrong");
   AST_IN_TYPE: assert property ((r.age == 2'h3) |->
      (mode_b[BIT_IN_TYPE] == $past(rxb_input_type_flag, 2)))
      else $error("input type bit wrong");
   AST_LANE_CONFIG_SELECT: assert property ((r.age == 2'h3) |-> (mode_a[4:0] ==
      (($past(lane_config_select, 2) <= CFG_SAFE_MAX) ? LANE_MODE_SAFE
       : $past(txa_lane_operating_mode, 2))))
      else $error("operating mode field wrong");
   AST_TERM_CM: assert property ((r.age == 2'h3) |->
      (sig_a[7:6] == {$past(txa_far_termination_seen, 2), $past(txa_common_mode_state, 2)}))
      else $error("termination or common-mode bit wrong");
   AST_TXSET: assert property ((r.age == 2'h3) |->
      (txset_b == {3'h0, $past(rxb_swing_emphasis_setting, 2)}))
      else $error("swing setting byte wrong");
   AST_LOCK: assert property ((r.age == 2'h3) |-> (lock_a ==
      {2'h0, $past(txa_recovery_loop_locked, 2), $past(txa_synth_loop_locked, 2), 4'h0}))
      else $error("lock byte wrong");
   AST_EQ: assert property ((r.age == 2'h3) |-> (eq_a ==
      {2'h0, $past(txa_equalizer_cal_finished, 2), 1'h0, $past(txa_equalizer_code, 2)}))
      else $error("equalizer byte wrong");
   AST_PD_POWERUP: assert property ($rose(reset_n) |-> pd_a[BIT_PD_N] ##2
      (pd_a[BIT_PD_N] == $past(txa_powerdown_n_status, 2)))
      else $error("power-down bit wrong after reset");
   AST_MSG: assert property ((r.age == 2'h3) |-> (pd_a[4:2] ==
      {$past(txa_msg_dual_lane_flag, 2), $past(txa_msg_data_rate_flag, 2),
       $past(txa_msg_warm_restart_flag, 2)}))
      else $error("decoded message bits wrong");
   AST_RSVD: assert property ((r.ptr == OFF_TXA_RSVD) |-> (rd_cur == RSVD_VALUE))
      else $error("reserved byte not zero");
   AST_RD_LOAD: assert property ((r.st == ST_ADDR_ACK) && scl_fall && r.rw |=>
      (r.tx == $past(rd_cur)) && (r.sda_oe == !$past(rd_cur[7])))
      else $error("read byte not loaded from live status");

endmodule

// ==== lsm_pkg.sv ====
package lsm_pkg;

   // serial port slave address; value is arbitrary
   localparam logic [6:0] SLAVE_ADDR     = 7'h5A;

   // byte offsets of the monitor bytes
   localparam logic [7:0] OFF_RXB_MODE   = 8'h33;
   localparam logic [7:0] OFF_RXB_SIG    = 8'h34;
   localparam logic [7:0] OFF_RXB_TXSET  = 8'h35;
   localparam logic [7:0] OFF_TXA_LOCK   = 8'h37;
   localparam logic [7:0] OFF_TXA_EQ     = 8'h38;
   localparam logic [7:0] OFF_TXA_RSVD   = 8'h39;
   localparam logic [7:0] OFF_TXA_PD     = 8'h3A;
   localparam logic [7:0] OFF_TXA_MODE   = 8'h3C;
   localparam logic [7:0] OFF_TXA_SIG    = 8'h3D;

   // field positions
   localparam int BIT_HS_QUIET  = 7;
   localparam int BIT_LF_QUIET  = 6;
   localparam int BIT_IN_TYPE   = 5;
   localparam int BIT_TERM      = 7;
   localparam int BIT_CM        = 6;
   localparam int BIT_COMP_EN   = 5;
   localparam int BIT_CDR       = 5;
   localparam int BIT_PLL       = 4;
   localparam int BIT_EQ_DONE   = 5;
   localparam int BIT_PD_N      = 6;
   localparam int BIT_DUAL      = 4;
   localparam int BIT_RATE      = 3;
   localparam int BIT_WARM      = 2;

   // reset values and codes
   localparam logic [7:0] RSVD_VALUE     = 8'h00;
   localparam logic       RST_PD_N       = 1'h1;
   localparam logic       RST_STATUS     = 1'h0;
   localparam logic       RST_BUS        = 1'h1;
   localparam logic [4:0] COMP_OFF       = 5'h00;
   localparam logic [4:0] COMP_LOW       = 5'h0D;
   localparam logic [4:0] COMP_HIGH      = 5'h16;
   localparam logic [4:0] LANE_MODE_SAFE = 5'h00;
   localparam logic [3:0] CFG_SAFE_MAX   = 4'h1;
   localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

   typedef enum logic [7:0] {
      ST_IDLE     = 8'h01,
      ST_ADDR     = 8'h02,
      ST_ADDR_ACK = 8'h04,
      ST_PTR      = 8'h08,
      ST_ACK_WR   = 8'h10,
      ST_WR_DATA  = 8'h20,
      ST_RD_DATA  = 8'h40,
      ST_RD_ACK   = 8'h80
   } lsm_i2c_st_t;

endpackage

// ==== lsm_sync.sv ====
`timescale 1ns/10ps
module lsm_sync
   import lsm_pkg::*;
#(
   parameter int         WIDTH   = 1,
   parameter logic       RST_VAL = 1'h0
)
(
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   // level in, level out
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } lsm_sync_t;

   lsm_sync_t r;
   lsm_sync_t next_r;

   // first stage feeds only the second
   always_comb
   begin
      next_r.s1 = din;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         r <= {(2 * WIDTH){RST_VAL}};
      end
      else
      begin
         r <= next_r;
      end
   end

   assign dout = r.s2;

endmodule

// ==== lsm_comp_step.sv ====
`timescale 1ns/10ps
module lsm_comp_step
   import lsm_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   // synced lane status
   input  wire logic       comp_en,
   input  wire logic       ping,
   // compliance state
   output logic      [4:0] comp_state
);

   typedef struct packed {
      logic       ping_d;
      logic [4:0] state;
   } lsm_comp_t;

   lsm_comp_t r;
   lsm_comp_t next_r;

   always_comb
   begin
      next_r = r;
      next_r.ping_d = ping;
      if (!comp_en)
      begin
         next_r.state = COMP_OFF;
      end
      else if (r.state == COMP_OFF)
      begin
         next_r.state = COMP_LOW;
      end
      else if (ping && !r.ping_d)
      begin
         next_r.state = (r.state >= COMP_HIGH) ? COMP_LOW : r.state + 5'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign comp_state = r.state;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence ping_edge_s;
      comp_en && (r.state != COMP_OFF) && ping && !r.ping_d;
   endsequence

   sequence stay_in_test_s;
      ##1 comp_en;
   endsequence

   AST_COMP_RANGE: assert property ((comp_state == COMP_OFF) ||
      ((comp_state >= COMP_LOW) && (comp_state <= COMP_HIGH)))
      else $error("compliance state out of range");

   AST_COMP_ADVANCE: assert property (ping_edge_s ##0 stay_in_test_s |->
      (comp_state == (($past(comp_state) == COMP_HIGH) ? COMP_LOW
                      : $past(comp_state) + 5'h01)))
      else $error("compliance state did not step on ping");

   AST_COMP_OFF: assert property (!comp_en |=> (comp_state == COMP_OFF))
      else $error("compliance state not cleared in normal mode");

endmodule

// ==== lsm_host.sv ====
`timescale 1ns/10ps
module lsm_host
   import lsm_pkg::*;
(
   // clock
   input  wire logic       sys_clk,
   // serial wire
   output logic            scl,
   output logic            sda_in,
   input  wire logic       sda_out,
   input  wire logic       sda_oe,
   // read result
   output logic            rd_stb,
   output logic      [7:0] rd_data
);
   logic drv;
   // open drain: the pull-up wins only when nobody pulls low
   assign sda_in = drv & (sda_oe ? sda_out : 1'b1);
   initial
   begin
      scl = 1'b1;
      drv = 1'b1;
      rd_stb = 1'b0;
      rd_data = 8'h00;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // data moves mid-low so it never races an scl edge
   task automatic bit_io(input logic v, output logic s);
      drv = v;
      wt(10);
      scl = 1'b1;
      wt(10);
      s = sda_in;
      scl = 1'b0;
      wt(5);
   endtask
   task automatic start();
      drv = 1'b1;
      wt(10);
      scl = 1'b1;
      wt(10);
      drv = 1'b0;
      wt(10);
      scl = 1'b0;
      wt(5);
   endtask
   task automatic stop();
      drv = 1'b0;
      wt(10);
      scl = 1'b1;
      wt(10);
      drv = 1'b1;
      wt(10);
   endtask
   task automatic put_byte(input logic [7:0] b, output logic nack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], s);
      bit_io(1'b1, nack);
   endtask
   task automatic get_byte(input logic last);
      logic       s;
      logic [7:0] d;
      for (int i = 0; i < 8; i++)
      begin
         bit_io(1'b1, s);
         d = {d[6:0], s};
      end
      bit_io(last, s);
      rd_data = d;
      rd_stb = 1'b1;
      wt(1);
      rd_stb = 1'b0;
   endtask
   task automatic read(input logic [7:0] ptr, input int n);
      logic a;
      start();
      put_byte({SLAVE_ADDR, 1'b0}, a);
      put_byte(ptr, a);
      start();
      put_byte({SLAVE_ADDR, 1'b1}, a);
      for (int i = 0; i < n; i++)
         get_byte(i == n - 1);
      stop();
   endtask
   task automatic write(input logic [7:0] ptr, input logic [7:0] d, output logic nack);
      logic a;
      start();
      put_byte({SLAVE_ADDR, 1'b0}, a);
      put_byte(ptr, a);
      put_byte(d, nack);
      stop();
   endtask
   task automatic probe(input logic [6:0] adr, output logic nack);
      start();
      put_byte({adr, 1'b0}, nack);
      stop();
   endtask
endmodule

// ==== lsm_monitor_tb.sv ====
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((e) !== (g)) begin failures++; \
   $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module lsm_monitor_tb;
   import lsm_pkg::*;
   logic        sys_clk;
   logic        reset_n;
   logic        scl;
   logic        sda_in;
   logic        sda_out;
   logic        sda_oe;
   logic        rd_stb;
   logic  [7:0] rd_data;
   logic  [3:0] cfg;
   logic [35:0] s;
   logic  [1:0] comp;
   logic  [1:0] ping;
   logic  [4:0] cs_rx;
   logic  [4:0] cs_tx;
   logic        nack;
   logic  [7:0] ex;
   string       nm;
   integer      seed;
   int          failures;
   int          comparisons;
   int          cycles;
   string       nq[$];
   logic  [7:0] eq[$];

   lsm_monitor dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe(sda_oe), .lane_config_select(cfg),
      .rxb_highspeed_quiet_flag(s[0]), .rxb_lowfreq_signal_quiet_flag(s[1]),
      .rxb_input_type_flag(s[2]), .rxb_lane_operating_mode(s[7:3]),
      .rxb_far_termination_seen(s[8]), .rxb_common_mode_state(s[9]),
      .rxb_compliance_active(comp[0]), .rxb_adjacent_ping(ping[0]),
      .rxb_swing_emphasis_setting(s[14:10]),
      .txa_highspeed_quiet_flag(s[15]), .txa_lowfreq_signal_quiet_flag(s[16]),
      .txa_input_type_flag(s[17]), .txa_lane_operating_mode(s[22:18]),
      .txa_far_termination_seen(s[23]), .txa_common_mode_state(s[24]),
      .txa_compliance_active(comp[1]), .txa_adjacent_ping(ping[1]),
      .txa_recovery_loop_locked(s[25]), .txa_synth_loop_locked(s[26]),
      .txa_equalizer_cal_finished(s[27]), .txa_equalizer_code(s[31:28]),
      .txa_powerdown_n_status(s[32]), .txa_msg_dual_lane_flag(s[33]),
      .txa_msg_data_rate_flag(s[34]), .txa_msg_warm_restart_flag(s[35])
   );
   lsm_host host (
      .sys_clk(sys_clk), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
      .sda_oe(sda_oe), .rd_stb(rd_stb), .rd_data(rd_data)
   );

   initial
      sys_clk = 1'b0;
   always #2 sys_clk = ~sys_clk;

   function automatic logic [7:0] exp_byte(input logic [7:0] off);
      logic       safe;
      logic [1:0] en;
      safe = (cfg <= CFG_SAFE_MAX);
      en = safe ? 2'h0 : comp;
      case (off)
         OFF_RXB_MODE:  exp_byte = {s[0], s[1], s[2], safe ? LANE_MODE_SAFE : s[7:3]};
         OFF_RXB_SIG:   exp_byte = {s[8], s[9], en[0], en[0] ? cs_rx : COMP_OFF};
         OFF_RXB_TXSET: exp_byte = {3'h0, s[14:10]};
         OFF_TXA_LOCK:  exp_byte = {2'h0, s[25], s[26], 4'h0};
         OFF_TXA_EQ:    exp_byte = {2'h0, s[27], 1'h0, s[31:28]};
         OFF_TXA_PD:    exp_byte = {1'h0, s[32], 1'h0, s[33], s[34], s[35], 2'h0};
         OFF_TXA_MODE:  exp_byte = {s[15], s[16], s[17], safe ? LANE_MODE_SAFE : s[22:18]};
         OFF_TXA_SIG:   exp_byte = {s[23], s[24], en[1], en[1] ? cs_tx : COMP_OFF};
         default:       exp_byte = RSVD_VALUE;
      endcase
   endfunction

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // note expectations first; the watcher pairs them in order
   task automatic read_chk(input logic [7:0] ptr, input int n);
      for (int i = 0; i < n; i++)
      begin
         nq.push_back($sformatf("byte %0h", 8'(ptr + i)));
         eq.push_back(exp_byte(8'(ptr + i)));
      end
      host.read(ptr, n);
   endtask

   task end_sim();
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge rd_stb)
   begin
      nm = nq.pop_front();
      ex = eq.pop_front();
      `CHK(nm, ex, rd_data)
   end

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         failures++;
         end_sim();
      end
   end

   initial
   begin
      seed = 30;
      reset_n = 1'b0;
      cfg = 4'h2;
      s = 36'h0;
      comp = 2'h0;
      ping = 2'h0;
      cs_rx = COMP_LOW;
      cs_tx = COMP_LOW;
      failures = 0;
      comparisons = 0;
      cycles = 0;
      wt(4);
      reset_n = 1'b1;
      wt(3);
      host.probe(SLAVE_ADDR ^ 7'h01, nack);
      `CHK("foreign address nack", 1'b1, nack)
      // safe codes first, then random live status
      for (int i = 0; i < 6; i++)
      begin
         cfg = (i < 2) ? 4'(i) : 4'(2 + ({$random(seed)} % 14));
         s = 36'({$random(seed), $random(seed)});
         wt(4);
         read_chk(OFF_RXB_MODE, 11);
      end
      // writes accepted on the wire but discarded
      host.write(OFF_RXB_MODE, ~exp_byte(OFF_RXB_MODE), nack);
      `CHK("write ack", 1'b0, nack)
      host.write(OFF_TXA_RSVD, 8'hFF, nack);
      read_chk(OFF_RXB_MODE, 2);
      read_chk(OFF_TXA_RSVD, 1);
      read_chk(8'hFF, 2);
      // ping steps with wrap at the upper bound
      comp = 2'h3;
      cfg = 4'h5;
      wt(6);
      for (int j = 0; j < 11; j++)
      begin
         ping = (j < 3) ? 2'h3 : 2'h1;
         cs_rx = (cs_rx == COMP_HIGH) ? COMP_LOW : cs_rx + 5'h01;
         cs_tx = (j < 3) ? cs_tx + 5'h01 : cs_tx;
         wt(4);
         ping = 2'h0;
         wt(4);
      end
      read_chk(OFF_RXB_SIG, 1);
      read_chk(OFF_TXA_SIG, 1);
      cfg = 4'h1;
      wt(6);
      read_chk(OFF_RXB_SIG, 1);
      wt(20);
      end_sim();
   end
endmodule
